// *** common/fsla_pkg.sv ***
// Constants, zone map, register map and carrier types for the fuse and security level logic.
package fsla_pkg;

   // ----------------------------------------------------------------
   // Address counter and zone boundaries (last bit of each zone)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 11;
   typedef logic [ADDR_W-1:0] fsla_addr_t;

   localparam fsla_addr_t FAB_END = 11'h00F;
   localparam fsla_addr_t ISSUER_END = 11'h04F;
   localparam fsla_addr_t CODE_END = 11'h05F;
   localparam fsla_addr_t ATTEMPT_END = 11'h06F;
   localparam fsla_addr_t PROTECT_END = 11'h0AF;
   localparam fsla_addr_t AZ1_END = 11'h1AF;
   localparam fsla_addr_t EZ1_END = 11'h1DF;
   localparam fsla_addr_t AZ2_END = 11'h2DF;
   localparam fsla_addr_t EZ2_END = 11'h2FF;
   localparam fsla_addr_t COUNTER_END = 11'h37F;
   localparam fsla_addr_t TEST_END = 11'h38F;
   localparam fsla_addr_t MAKER_END = 11'h3FF;
   localparam fsla_addr_t AZ3_END = 11'h5FF;
   localparam fsla_addr_t EZ3_END = 11'h62F;

   // Read-enable bits: the second bit of each application zone.
   localparam fsla_addr_t AZ1_READ_BIT = 11'h0B1;
   localparam fsla_addr_t AZ2_READ_BIT = 11'h1E1;
   localparam fsla_addr_t AZ3_READ_BIT = 11'h401;

   // ----------------------------------------------------------------
   // Zones, operations and fuse encoding
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ZONE_FAB = 4'b0000,
      ZONE_ISSUER = 4'b0001,
      ZONE_CODE = 4'b0010,
      ZONE_ATTEMPT = 4'b0011,
      ZONE_PROTECT = 4'b0100,
      ZONE_AZ1 = 4'b0101,
      ZONE_EZ1 = 4'b0110,
      ZONE_AZ2 = 4'b0111,
      ZONE_EZ2 = 4'b1000,
      ZONE_COUNTER = 4'b1001,
      ZONE_TEST = 4'b1010,
      ZONE_MAKER = 4'b1011,
      ZONE_AZ3 = 4'b1100,
      ZONE_EZ3 = 4'b1101,
      ZONE_NONE = 4'b1110
   } fsla_zone_e;

   typedef struct packed {
      logic read;
      logic erase;
      logic write;
      logic compare;
   } fsla_op_s;

   localparam fsla_op_s OP_NONE = 4'h0;
   localparam logic FUSE_BLOWN = 1'b0;
   localparam logic FUSE_UNBLOWN = 1'b1;
   localparam logic [7:0] ERASE_LIMIT = 8'h80;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_STEP = 8'h01;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   typedef logic [7:0] fsla_reg_addr_t;
   typedef logic [7:0] fsla_data_t;

   localparam fsla_reg_addr_t REG_CONTROL = 8'h00;
   localparam fsla_reg_addr_t REG_STATUS = 8'h04;
   localparam fsla_reg_addr_t REG_COUNT = 8'h08;
   localparam fsla_data_t DATA_ZERO = 8'h00;

   // Control register: write 1 to blow a fuse; the counter enable fuse blows only while the issuer fuse is unblown.
   localparam int CTL_BLOW_ISSUER = 0;
   localparam int CTL_BLOW_MAKER = 1;
   localparam int CTL_BLOW_COUNT_EN = 2;

   // Status register fields.
   localparam int ST_ISSUER = 0;
   localparam int ST_MAKER = 1;
   localparam int ST_COUNT_EN = 2;
   localparam int ST_LEVEL_TWO = 3;
   localparam int ST_CODE_VALID = 4;
   localparam int ST_READ_ONE = 5;
   localparam int ST_READ_TWO = 6;
   localparam int ST_READ_THREE = 7;

   typedef struct packed {
      fsla_reg_addr_t address;
      fsla_data_t write_data;
      logic write_strobe;
      logic read_strobe;
   } fsla_bus_s;

endpackage

// *** verilog/fsla_access.sv ***
// Fuse state, security level selection and zone permission checking.
`timescale 1ns/100ps

module fsla_access
   import fsla_pkg::*;
(
   input wire logic i_clock, // 25 MHz clock
   input wire logic i_reset_n, // Asynchronous reset, active low
   input wire fsla_pkg::fsla_bus_s i_bus, // Register bus request
   output fsla_pkg::fsla_data_t o_read_data, // Read data, cycle after strobe
   input wire logic i_personalization_pin, // Asynchronous pin, low forces level two
   input wire fsla_pkg::fsla_addr_t i_address, // Current address counter value
   input wire logic i_bit_data, // Stored value of the addressed bit
   input wire logic i_code_ok, // Pulse: security code validated
   input wire fsla_pkg::fsla_op_s i_request, // One-cycle operation request
   input wire fsla_pkg::fsla_op_s i_level_two_grant, // Level two matrix verdict
   output fsla_pkg::fsla_op_s o_perform, // Granted operation, registered
   output logic o_level_two // High while in security level two
);
   import fsla_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic issuer;
      logic maker;
      logic count_en;
      logic code_valid;
      logic read_one;
      logic read_two;
      logic read_three;
      logic pin_meta;
      logic pin_sync;
      logic [7:0] erase_count;
      fsla_op_s perform;
      fsla_data_t read_data;
   } fsla_state_s;

   localparam fsla_state_s STATE_RESET = '{
      issuer: FUSE_UNBLOWN,
      maker: FUSE_UNBLOWN,
      count_en: FUSE_UNBLOWN,
      code_valid: 1'b0,
      read_one: 1'b0,
      read_two: 1'b0,
      read_three: 1'b0,
      pin_meta: 1'b1,
      pin_sync: 1'b1,
      erase_count: COUNT_RESET,
      perform: OP_NONE,
      read_data: DATA_ZERO
   };

   fsla_state_s state;
   fsla_state_s next_state;
   fsla_zone_e zone;
   fsla_op_s allowed;
   logic level_two;
   logic maker_effective;
   logic limit_reached;

   // ----------------------------------------------------------------
   // Zone decode and level one matrix
   // ----------------------------------------------------------------
   function automatic fsla_zone_e zone_of(input fsla_addr_t a);
      fsla_zone_e z;
      if (a <= FAB_END) z = ZONE_FAB;
      else if (a <= ISSUER_END) z = ZONE_ISSUER;
      else if (a <= CODE_END) z = ZONE_CODE;
      else if (a <= ATTEMPT_END) z = ZONE_ATTEMPT;
      else if (a <= PROTECT_END) z = ZONE_PROTECT;
      else if (a <= AZ1_END) z = ZONE_AZ1;
      else if (a <= EZ1_END) z = ZONE_EZ1;
      else if (a <= AZ2_END) z = ZONE_AZ2;
      else if (a <= EZ2_END) z = ZONE_EZ2;
      else if (a <= COUNTER_END) z = ZONE_COUNTER;
      else if (a <= TEST_END) z = ZONE_TEST;
      else if (a <= MAKER_END) z = ZONE_MAKER;
      else if (a <= AZ3_END) z = ZONE_AZ3;
      else if (a <= EZ3_END) z = ZONE_EZ3;
      else z = ZONE_NONE;
      return z;
   endfunction

   // Fields in order: read, erase, write, compare.
   function automatic fsla_op_s level_one(input fsla_zone_e z, input logic sv,
         input logic r1, input logic r2, input logic r3, input logic mf);
      fsla_op_s p;
      p = OP_NONE;
      unique case (z)
         ZONE_FAB: p = '{1'b1, 1'b0, 1'b0, 1'b0};
         ZONE_TEST: p = '{1'b1, 1'b1, 1'b1, 1'b0};
         ZONE_CODE: p = '{sv, sv, sv, ~sv};
         ZONE_ATTEMPT, ZONE_COUNTER:
            p = '{1'b1, sv, 1'b1, 1'b0};
         ZONE_ISSUER, ZONE_PROTECT:
            p = '{1'b1, sv, sv, 1'b0};
         ZONE_EZ1, ZONE_EZ2, ZONE_EZ3:
            p = '{sv, sv, sv, 1'b0};
         ZONE_AZ1: p = '{sv | r1, sv, sv, 1'b0};
         ZONE_AZ2: p = '{sv | r2, sv, sv, 1'b0};
         ZONE_AZ3: p = '{sv | r3, sv, sv, 1'b0};
         ZONE_MAKER: p = '{1'b1, sv & mf, sv & mf, 1'b0};
         ZONE_NONE: p = OP_NONE;
      endcase
      return p;
   endfunction

   // ----------------------------------------------------------------
   // Combinational decisions
   // ----------------------------------------------------------------
   assign zone = zone_of(i_address);
   // The issuer fuse reads 0 when blown, so a blown issuer also disables the maker fuse.
   assign maker_effective = state.maker & state.issuer;
   assign level_two = (state.issuer == FUSE_BLOWN) | ~state.pin_sync;
   assign limit_reached = state.erase_count >= ERASE_LIMIT;
   assign o_level_two = level_two;
   assign o_perform = state.perform;
   assign o_read_data = state.read_data;

   always_comb
   begin
      allowed = level_one(zone, state.code_valid, state.read_one, state.read_two,
                          state.read_three, maker_effective);
      if (level_two)
      begin
         allowed = i_level_two_grant;
         // The counter only restricts while its enable fuse is unblown.
         if (zone == ZONE_AZ2 && state.count_en == FUSE_UNBLOWN && limit_reached)
         begin
            allowed.erase = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      // The pin is asynchronous; only the second stage is used.
      next_state.pin_meta = i_personalization_pin;
      next_state.pin_sync = state.pin_meta;
      next_state.perform = i_request & allowed;

      if (i_code_ok)
      begin
         next_state.code_valid = 1'b1;
      end

      // Zone one and two read-enable bits are sampled when the counter passes them; the zone three flag only sets, on a 1.
      if (i_address == AZ1_READ_BIT)
      begin
         next_state.read_one = i_bit_data;
      end
      if (i_address == AZ2_READ_BIT)
      begin
         next_state.read_two = i_bit_data;
      end
      if (i_address == AZ3_READ_BIT && i_bit_data)
      begin
         next_state.read_three = 1'b1;
      end

      if (level_two && zone == ZONE_AZ2 && state.count_en == FUSE_UNBLOWN
          && i_request.erase && allowed.erase)
      begin
         next_state.erase_count = state.erase_count + COUNT_STEP;
      end

      if (i_bus.write_strobe && i_bus.address == REG_CONTROL)
      begin
         if (i_bus.write_data[CTL_BLOW_ISSUER])
         begin
            next_state.issuer = FUSE_BLOWN;
         end
         if (i_bus.write_data[CTL_BLOW_MAKER])
         begin
            next_state.maker = FUSE_BLOWN;
         end
         if (i_bus.write_data[CTL_BLOW_COUNT_EN] && state.issuer == FUSE_UNBLOWN)
         begin
            next_state.count_en = FUSE_BLOWN;
         end
      end

      next_state.read_data = DATA_ZERO;
      if (i_bus.read_strobe)
      begin
         unique case (i_bus.address)
            REG_STATUS:
            begin
               next_state.read_data[ST_ISSUER] = state.issuer;
               next_state.read_data[ST_MAKER] = maker_effective;
               next_state.read_data[ST_COUNT_EN] = state.count_en;
               next_state.read_data[ST_LEVEL_TWO] = level_two;
               next_state.read_data[ST_CODE_VALID] = state.code_valid;
               next_state.read_data[ST_READ_ONE] = state.read_one;
               next_state.read_data[ST_READ_TWO] = state.read_two;
               next_state.read_data[ST_READ_THREE] = state.read_three;
            end
            REG_COUNT: next_state.read_data = state.erase_count;
            default: next_state.read_data = DATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state <= STATE_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);

   sequence level_one_req(fsla_zone_e z);
      !level_two && zone == z && state.pin_sync;
   endsequence

   sequence az2_erase_req;
      level_two && zone == ZONE_AZ2 && i_request.erase && i_level_two_grant.erase;
   endsequence

   issuer_level_a: assert property ($fell(state.issuer) |=> o_level_two [*3])
      else $error("Blown issuer fuse did not hold level two.");

   pin_low_a: assert property (!i_personalization_pin [*3] |-> o_level_two)
      else $error("Low personalization pin did not force level two.");

   maker_write_a: assert property (level_one_req(ZONE_MAKER) ##0 i_request.write
         |=> o_perform.write == $past(state.code_valid && state.issuer && state.maker))
      else $error("Maker zone write grant wrong.");

   count_frozen_a: assert property (!state.issuer |=> $stable(state.count_en))
      else $error("Counter enable fuse changed after issuer fuse blew.");

   erase_limit_a: assert property (az2_erase_req ##0 state.count_en && limit_reached
         |=> !o_perform.erase && $stable(state.erase_count))
      else $error("Zone two erase passed the erase limit.");

   erase_free_a: assert property (az2_erase_req ##0 !state.count_en
         |=> o_perform.erase ##1 $stable(state.erase_count))
      else $error("Zone two erase wrongly limited.");

   code_compare_a: assert property (level_one_req(ZONE_CODE) ##0 !state.code_valid
         ##0 i_request.read |=> !o_perform.read)
      else $error("Security code zone readable without validation.");

   test_zone_a: assert property (level_one_req(ZONE_TEST) ##0 i_request.erase
         |=> o_perform.erase)
      else $error("Test zone erase denied in level one.");

   zone_one_read_a: assert property (level_one_req(ZONE_AZ1) ##0 !state.code_valid
         ##0 i_request.read |=> o_perform.read == $past(state.read_one))
      else $error("Zone one read not gated by its read-enable bit.");

   read_three_hold_a: assert property (state.read_three |=> state.read_three [*4])
      else $error("Zone three read flag dropped.");

   code_valid_a: assert property ($rose(state.code_valid) |-> $past(i_code_ok))
      else $error("Code valid flag set without validation.");

   maker_read_a: assert property (level_one_req(ZONE_MAKER) ##0 i_request.read
         |=> o_perform.read)
      else $error("Maker zone read denied.");

   maker_erase_a: assert property (level_one_req(ZONE_MAKER) ##0 i_request.erase
         |=> o_perform.erase == $past(state.code_valid && state.issuer && state.maker))
      else $error("Maker zone erase grant wrong.");

   maker_status_a: assert property (i_bus.read_strobe && i_bus.address == REG_STATUS
         && state.issuer == FUSE_BLOWN |=> o_read_data[ST_MAKER] == FUSE_BLOWN)
      else $error("Maker fuse reported unblown after the issuer fuse blew.");

   count_cap_a: assert property (state.count_en == FUSE_UNBLOWN
         |-> state.erase_count <= ERASE_LIMIT)
      else $error("Zone two erase count beyond its limit.");

   issuer_blow_a: assert property (i_bus.write_strobe && i_bus.address == REG_CONTROL
         && i_bus.write_data[CTL_BLOW_ISSUER] |=> state.issuer == FUSE_BLOWN)
      else $error("Issuer fuse did not blow.");

   issuer_sticky_a: assert property (state.issuer == FUSE_BLOWN
         |=> state.issuer == FUSE_BLOWN)
      else $error("Issuer fuse returned to unblown.");

   level_one_a: assert property (state.issuer == FUSE_UNBLOWN && state.pin_sync
         |-> !o_level_two)
      else $error("Level two without a blown fuse or a low pin.");

   code_sticky_a: assert property (state.code_valid |=> state.code_valid)
      else $error("Code valid flag cleared without reset.");

   erase_code_a: assert property (!level_two && !state.code_valid
         && (zone == ZONE_EZ1 || zone == ZONE_EZ2 || zone == ZONE_EZ3)
         |=> o_perform == OP_NONE)
      else $error("Erase code zone reachable without validation.");

   fab_readonly_a: assert property (level_one_req(ZONE_FAB)
         |=> !o_perform.erase && !o_perform.write && !o_perform.compare)
      else $error("Fabrication zone altered in level one.");

   app_locked_a: assert property (!level_two && !state.code_valid
         && (zone == ZONE_AZ1 || zone == ZONE_AZ2 || zone == ZONE_AZ3)
         |=> !o_perform.erase && !o_perform.write)
      else $error("Application zone altered without validation.");

   zone_two_read_a: assert property (level_one_req(ZONE_AZ2) ##0 !state.code_valid
         ##0 i_request.read |=> o_perform.read == $past(state.read_two))
      else $error("Zone two read not gated by its read-enable bit.");

   zone_three_read_a: assert property (level_one_req(ZONE_AZ3) ##0 !state.code_valid
         ##0 i_request.read |=> o_perform.read == $past(state.read_three))
      else $error("Zone three read not gated by its read flag.");

   level_two_pass_a: assert property (level_two && zone != ZONE_AZ2
         |=> o_perform == $past(i_request & i_level_two_grant))
      else $error("Level two operation differs from the grant.");

   idle_perform_a: assert property (i_request == OP_NONE |=> o_perform == OP_NONE)
      else $error("Operation performed without a request.");

endmodule

// *** dv/fsla_reader_model.sv ***
// Card reader model: address counter, bit data, requests, code pulse and personalization pin.
`timescale 1ns/100ps
module fsla_reader_model (
   input wire logic i_clock, // Device clock
   output fsla_pkg::fsla_addr_t o_address, // Address counter value
   output logic o_bit_data, // Stored bit of the addressed cell
   output logic o_code_ok, // Code validation pulse
   output fsla_pkg::fsla_op_s o_request, // Operation request
   output fsla_pkg::fsla_op_s o_grant, // Level two verdict
   output logic o_personalization_pin // Low selects level two
);
   import fsla_pkg::*;
   initial
   begin
      o_address = '0;
      o_bit_data = 1'b0;
      o_code_ok = 1'b0;
      o_request = OP_NONE;
      o_grant = OP_NONE;
      o_personalization_pin = 1'b1;
   end
   // One request cycle; the bit line keeps its value while the cell stays addressed.
   task automatic op(input fsla_addr_t a, input logic b, input logic [3:0] rq,
                     input logic [3:0] gr);
      @(posedge i_clock);
      o_address <= a;
      o_bit_data <= b;
      o_request <= rq;
      o_grant <= gr;
      @(posedge i_clock);
      o_request <= OP_NONE;
   endtask
   task automatic code();
      @(posedge i_clock);
      o_code_ok <= 1'b1;
      @(posedge i_clock);
      o_code_ok <= 1'b0;
   endtask
   task automatic pin(input logic v);
      @(posedge i_clock);
      o_personalization_pin <= v;
   endtask
endmodule

// *** dv/tb.sv ***
// Self-checking testbench for the fuse and security level access block.
`timescale 1ns/100ps
module tb;
   import fsla_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   fsla_bus_s bus = '0;
   fsla_data_t rdata;
   fsla_addr_t addr;
   logic bitd, code_ok, pin, lvl_out;
   fsla_op_s request, grant, perform;
   int n_fail = 0;
   int comparisons = 0;
   logic iss, maker_zone, cen, sv, f1, f2, f3, lvl2;

   fsla_access u_dut (.i_clock(clock), .i_reset_n(reset_n), .i_bus(bus), .o_read_data(rdata),
      .i_personalization_pin(pin), .i_address(addr), .i_bit_data(bitd), .i_code_ok(code_ok),
      .i_request(request), .i_level_two_grant(grant), .o_perform(perform), .o_level_two(lvl_out));
   fsla_reader_model u_reader (.i_clock(clock), .o_address(addr), .o_bit_data(bitd),
      .o_code_ok(code_ok), .o_request(request), .o_grant(grant), .o_personalization_pin(pin));

   initial
   begin
      forever #20 clock = ~clock;
   end

   // ----------------------------------------
   // Expectations
   // ----------------------------------------
   function automatic logic [3:0] perm(input fsla_addr_t a);
      if (a <= FAB_END) return 4'h8;
      if (a <= ISSUER_END) return sv ? 4'hE : 4'h8;
      if (a <= CODE_END) return sv ? 4'hE : 4'h1;
      if (a <= ATTEMPT_END) return sv ? 4'hE : 4'hA;
      if (a <= PROTECT_END) return sv ? 4'hE : 4'h8;
      if (a <= AZ1_END) return sv ? 4'hE : {f1, 3'b000};
      if (a <= EZ1_END) return sv ? 4'hE : 4'h0;
      if (a <= AZ2_END) return sv ? 4'hE : {f2, 3'b000};
      if (a <= EZ2_END) return sv ? 4'hE : 4'h0;
      if (a <= COUNTER_END) return sv ? 4'hE : 4'hA;
      if (a <= TEST_END) return 4'hE;
      if (a <= MAKER_END) return (sv && maker_zone && iss) ? 4'hE : 4'h8;
      if (a <= AZ3_END) return sv ? 4'hE : {f3, 3'b000};
      if (a <= EZ3_END) return sv ? 4'hE : 4'h0;
      return 4'h0;
   endfunction
   function automatic logic [7:0] st();
      return {f3, f2, f1, sv, lvl2, cen, maker_zone & iss, iss};
   endfunction

   // ----------------------------------------
   // Compares and drivers
   // ----------------------------------------
   task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t data got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_op(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t op got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t level got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input fsla_reg_addr_t a, input fsla_data_t d);
      @(posedge clock);
      bus <= {a, d, 2'b10};
      @(posedge clock);
      bus <= '0;
   endtask
   task automatic rd(input fsla_reg_addr_t a, input fsla_data_t exp);
      @(posedge clock);
      bus <= {a, DATA_ZERO, 2'b01};
      @(posedge clock);
      bus <= '0;
      @(negedge clock);
      chk_data(rdata, exp);
      @(negedge clock);
      chk_data(rdata, DATA_ZERO);
   endtask
   task automatic req(input fsla_addr_t a, input logic b, input logic [3:0] rq,
                      input logic [3:0] gr, input logic [3:0] exp);
      u_reader.op(a, b, rq, gr);
      @(negedge clock);
      chk_op(perform, exp);
   endtask
   // Read-enable cells are skipped: a flag changing under a request is out of scope.
   task automatic rand_ops(input int n);
      fsla_addr_t a;
      logic [3:0] rq, gr;
      repeat (n)
      begin
         a = fsla_addr_t'($urandom_range(0, lvl2 ? int'(EZ3_END) : 1599));
         if (a == AZ1_READ_BIT || a == AZ2_READ_BIT || a == AZ3_READ_BIT) a++;
         rq = 4'($urandom);
         gr = 4'($urandom);
         if (lvl2 && a > EZ1_END && a <= AZ2_END) rq[2] = 1'b0;
         req(a, 1'($urandom), rq, gr, lvl2 ? (rq & gr) : (rq & perm(a)));
      end
   endtask
   task automatic do_reset();
      reset_n <= 1'b0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      {iss, maker_zone, cen, sv, f1, f2, f3, lvl2} = 8'hE0;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      n_fail++;
      conclude();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'h4172BFE7));
      do_reset();
      rd(REG_STATUS, st());
      rd(REG_COUNT, 8'h00);
      rd(8'h0C, 8'h00);
      chk_bit(lvl_out, 1'b0);
      $display("test reset done");
      for (int k = 0; k < 3; k++)
      begin
         f1 = 1'($urandom);
         f2 = 1'($urandom);
         req(AZ1_READ_BIT, f1, 4'h0, 4'h0, 4'h0);
         req(AZ2_READ_BIT, f2, 4'h0, 4'h0, 4'h0);
         req(AZ3_READ_BIT, k == 1, 4'h0, 4'h0, 4'h0);
         f3 = f3 | (k == 1);
         rd(REG_STATUS, st());
         rand_ops(60);
      end
      req(11'h050, 1'b0, 4'hF, 4'h0, 4'h1);
      req(11'h380, 1'b0, 4'hF, 4'h0, 4'hE);
      req(11'h005, 1'b0, 4'hF, 4'h0, 4'h8);
      $display("test level one locked done");
      u_reader.code();
      sv = 1'b1;
      rd(REG_STATUS, st());
      req(11'h390, 1'b0, 4'hF, 4'h0, 4'hE);
      wr(REG_CONTROL, 8'h02);
      maker_zone = 1'b0;
      req(11'h3A0, 1'b0, 4'hF, 4'h0, 4'h8);
      rd(REG_STATUS, st());
      rand_ops(100);
      $display("test level one open done");
      u_reader.pin(1'b0);
      lvl2 = 1'b1;
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk_bit(lvl_out, 1'b1);
      rd(REG_STATUS, st());
      rand_ops(100);
      for (int i = 0; i < 130; i++)
         req(11'h1F4, 1'b0, 4'h4, 4'h4, (i < 128) ? 4'h4 : 4'h0);
      rd(REG_COUNT, ERASE_LIMIT);
      wr(REG_CONTROL, 8'h04);
      cen = 1'b0;
      repeat (3) req(11'h1F4, 1'b0, 4'h4, 4'h4, 4'h4);
      rd(REG_COUNT, ERASE_LIMIT);
      rd(REG_STATUS, st());
      $display("test level two done");
      u_reader.pin(1'b1);
      do_reset();
      repeat (4) @(posedge clock);
      wr(REG_CONTROL, 8'h01);
      iss = 1'b0;
      lvl2 = 1'b1;
      rd(REG_STATUS, st());
      @(negedge clock);
      chk_bit(lvl_out, 1'b1);
      wr(REG_CONTROL, 8'h04);
      rd(REG_STATUS, st());
      rand_ops(40);
      $display("test issuer fuse done");
      conclude();
   end
endmodule
